// File: rtl/fifo_ctrl.sv
// Purpose: fifo control logic with bit-addressed storage and mixed widths
// Assumes: wr_tick and rd_tick are one-cycle enables of pclk for each domain
// Notes: pointers are kept one bit wider than the 12-bit address to tell full from empty
`timescale 1ns/100ps
`default_nettype none
module fifo_ctrl #(
  parameter bit WE_HIGH = fifo_pkg::WE_HIGH_DEFAULT,
  parameter bit RE_HIGH = fifo_pkg::RE_HIGH_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  fifo_if.device f
);

  localparam int PW = fifo_pkg::PTR_W + 1;
  localparam logic [PW:0] SPACE = (PW + 1)'(fifo_pkg::SPACE_BITS);

  initial begin
    if (fifo_pkg::PTR_W != 12 || fifo_pkg::DATA_W != 18) begin
      $error("fifo_ctrl serves only a 12-bit bit space and an 18-bit bus");
    end
  end

  // storage: 4096 main bits plus one extra bit per byte for the 9 and 18 widths
  logic mem [0:fifo_pkg::SPACE_BITS-1];
  logic extra [0:fifo_pkg::EXTRA_BITS-1];

  logic [PW-1:0] wptr;
  logic [PW-1:0] rptr;
  logic [PW-1:0] rptr_w1;
  logic [PW-1:0] rptr_w2;
  logic [PW-1:0] wptr_r1;
  logic [PW-1:0] wptr_r2;
  logic [17:0] rd_stage1;
  logic [17:0] rd_stage2;

  // width decode, reserved codes yield a zero step
  wire [4:0] wstep = fifo_pkg::addr_step(f.write_width_select);
  wire [4:0] rstep = fifo_pkg::addr_step(f.read_width_select);
  wire wcode_ok = (wstep != 5'h00);
  wire rcode_ok = (rstep != 5'h00);
  wire w9 = (f.write_width_select == fifo_pkg::WIDTH_9);
  wire w18 = (f.write_width_select == fifo_pkg::WIDTH_18);
  wire r9 = (f.read_width_select == fifo_pkg::WIDTH_9);
  wire r18 = (f.read_width_select == fifo_pkg::WIDTH_18);

  // fill levels are bit counts seen from each side
  wire [PW-1:0] fill_w = wptr - rptr_w2;
  wire [PW-1:0] fill_r = wptr_r2 - rptr;

  // full when a whole write word no longer fits
  wire full_now = ({1'b0, fill_w} + {{(PW-4){1'b0}}, wstep}) > SPACE;
  // empty when a whole read word is not there
  wire empty_now = fill_r < {{(PW-5){1'b0}}, rstep};

  wire we_act = WE_HIGH ? f.write_enable : ~f.write_enable;
  wire re_act = RE_HIGH ? f.read_enable : ~f.read_enable;

  wire wr_req = f.wr_tick & ~f.write_port_enable_n & we_act & wcode_ok;
  wire rd_req = f.rd_tick & ~f.read_port_enable_n & re_act & rcode_ok;

  // data moves only when the flag is clear
  // no store while full, so nothing is overwritten
  wire wr_store = wr_req & ~full_now;
  wire rd_fetch = rd_req & ~empty_now;
  // full halt freezes the write pointer at full
  wire wr_step = wr_req & (~full_now | ~f.full_halt);
  // empty halt freezes the read pointer at empty
  wire rd_step = rd_req & (~empty_now | ~f.empty_halt);

  wire [11:0] wa = wptr[11:0];
  wire [11:0] ra = rptr[11:0];
  wire [8:0] wa_x = wa[11:3];
  wire [8:0] ra_x = ra[11:3];

  // data bits that go to main storage: 9/18 widths drop their ninth bits there
  wire [15:0] wmain = (w9 | w18) ? {f.write_data_bus[16:9], f.write_data_bus[7:0]}
                                 : f.write_data_bus[15:0];

  // the store is gated by reset so storage stays untouched
  // storage has no reset; its contents survive
  always_ff @(posedge pclk) begin
    if (presetn && wr_store) begin
      for (int i = 0; i < fifo_pkg::MAIN_SLICE; i++) begin
        if (5'(i) < wstep) begin
          mem[wa + 12'(i)] <= wmain[i];
        end
      end
      if (w9 | w18) begin
        extra[wa_x] <= f.write_data_bus[8];
      end
      if (w18) begin
        extra[wa_x + 9'h001] <= f.write_data_bus[17];
      end
    end
  end

  // gather one read word; unused high bits come out as zero
  logic [15:0] rmain;
  always_comb begin
    rmain = 16'h0000;
    for (int i = 0; i < fifo_pkg::MAIN_SLICE; i++) begin
      if (5'(i) < rstep) begin
        rmain[i] = mem[ra + 12'(i)];
      end
    end
  end

  // only the low bits inside the read width are meaningful
  wire [17:0] rword = r18 ? {extra[ra_x + 9'h001], rmain[15:8], extra[ra_x], rmain[7:0]}
                    : r9 ? {9'h000, extra[ra_x], rmain[7:0]}
                    : {2'h0, rmain};

  // write pointer, one step per performed write
  // starts at zero and wraps past the last word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr <= '0;
    end else if (wr_step) begin
      wptr <= wptr + {{(PW-5){1'b0}}, wstep};
    end
  end

  // read pointer, one step per performed read
  // read side wraps the same way
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rptr <= '0;
    end else if (rd_step) begin
      rptr <= rptr + {{(PW-5){1'b0}}, rstep};
    end
  end

  // read pointer into the write domain, two write edges
  // this delay holds full for two write edges after a read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rptr_w1 <= '0;
      rptr_w2 <= '0;
    end else if (f.wr_tick) begin
      rptr_w1 <= rptr;
      rptr_w2 <= rptr_w1;
    end
  end

  // write pointer into the read domain, two read edges
  // this delay holds empty for two read edges after a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_r1 <= '0;
      wptr_r2 <= '0;
    end else if (f.rd_tick) begin
      wptr_r1 <= wptr;
      wptr_r2 <= wptr_r1;
    end
  end

  // read output registers; a disabled port keeps its last word
  // reset forces the output hold registers to zero
  // disabled read port holds the outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_stage1 <= 18'h00000;
      rd_stage2 <= 18'h00000;
    end else if (f.rd_tick && !f.read_port_enable_n) begin
      if (rd_fetch) begin
        rd_stage1 <= rword;
      end
      rd_stage2 <= rd_stage1;
    end
  end

  // pipelined read shows the word one read edge later
  assign f.read_data_bus = f.read_pipeline_select ? rd_stage2 : rd_stage1;

  // full is computed from write-domain registers only
  assign f.full = full_now;
  // empty is computed from read-domain registers only
  assign f.empty = empty_now;
  // near full at or above the threshold
  assign f.near_full_flag = fill_w >= {1'b0, f.near_full_threshold};
  // near empty at or below the threshold
  assign f.near_empty_flag = fill_r <= {1'b0, f.near_empty_threshold};

endmodule
`default_nettype wire

// File: rtl/fifo_pkg.sv
// Purpose: shared constants and helpers for the fifo controller and its user end
// Assumes: one clock; write and read domains are tick enables of that clock
// Notes: thresholds and pointers count data bits in a 4096-bit space
package fifo_pkg;

  // data buses and pointer sizes
  localparam int DATA_W = 18;
  localparam int PTR_W = 12;
  localparam int SPACE_BITS = 4096;
  localparam int MAIN_SLICE = 16;
  localparam int EXTRA_BITS = 512;

  // width select codes
  localparam logic [2:0] WIDTH_1 = 3'h0;
  localparam logic [2:0] WIDTH_2 = 3'h1;
  localparam logic [2:0] WIDTH_4 = 3'h2;
  localparam logic [2:0] WIDTH_9 = 3'h3;
  localparam logic [2:0] WIDTH_18 = 3'h4;

  // default enable polarity: write active low, read active high
  localparam bit WE_HIGH_DEFAULT = 1'b0;
  localparam bit RE_HIGH_DEFAULT = 1'b1;

  // tick dividers of the user end, in pclk cycles per active edge
  localparam int WR_DIV_DEFAULT = 2;
  localparam int RD_DIV_DEFAULT = 3;

  // register offsets of the user end
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_THRESH = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // control and threshold field positions
  localparam int CTRL_WW_LSB = 0;
  localparam int CTRL_RW_LSB = 3;
  localparam int CTRL_PIPE = 6;
  localparam int CTRL_EHALT = 7;
  localparam int CTRL_FHALT = 8;
  localparam int THR_NF_LSB = 0;
  localparam int THR_NE_LSB = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0124;
  localparam logic [31:0] THRESH_RESET = 32'h0000_0000;

  // pointer step per word in the bit space (9 and 18 count as 8 and 16)
  function automatic logic [4:0] addr_step(input logic [2:0] code);
    case (code)
      WIDTH_1: addr_step = 5'h01;
      WIDTH_2: addr_step = 5'h02;
      WIDTH_4: addr_step = 5'h04;
      WIDTH_9: addr_step = 5'h08;
      WIDTH_18: addr_step = 5'h10;
      default: addr_step = 5'h00;
    endcase
  endfunction

  // bits of the data bus that carry data for a width code
  function automatic logic [17:0] data_mask(input logic [2:0] code);
    case (code)
      WIDTH_1: data_mask = 18'h00001;
      WIDTH_2: data_mask = 18'h00003;
      WIDTH_4: data_mask = 18'h0000F;
      WIDTH_9: data_mask = 18'h001FF;
      WIDTH_18: data_mask = 18'h3FFFF;
      default: data_mask = 18'h00000;
    endcase
  endfunction

endpackage

// File: rtl/fifo_if.sv
// Purpose: wires between the fifo controller and the user logic that drives it
// Assumes: both ends run on pclk; the tick lines mark the active edges
// Notes: no clocking block; the bench joins the two ends through this
`timescale 1ns/100ps
`default_nettype none
interface fifo_if;
  logic wr_tick;
  logic write_port_enable_n;
  logic write_enable;
  logic [17:0] write_data_bus;
  logic [2:0] write_width_select;
  logic full_halt;
  logic [11:0] near_full_threshold;
  logic rd_tick;
  logic read_port_enable_n;
  logic read_enable;
  logic [2:0] read_width_select;
  logic read_pipeline_select;
  logic empty_halt;
  logic [11:0] near_empty_threshold;
  logic [17:0] read_data_bus;
  logic full;
  logic empty;
  logic near_full_flag;
  logic near_empty_flag;

  modport device (
    input wr_tick, write_port_enable_n, write_enable, write_data_bus, write_width_select,
    input full_halt, near_full_threshold, rd_tick, read_port_enable_n, read_enable,
    input read_width_select, read_pipeline_select, empty_halt, near_empty_threshold,
    output read_data_bus, full, empty, near_full_flag, near_empty_flag
  );

  modport user (
    output wr_tick, write_port_enable_n, write_enable, write_data_bus, write_width_select,
    output full_halt, near_full_threshold, rd_tick, read_port_enable_n, read_enable,
    output read_width_select, read_pipeline_select, empty_halt, near_empty_threshold,
    input read_data_bus, full, empty, near_full_flag, near_empty_flag
  );
endinterface
`default_nettype wire

// File: rtl/fifo_user.sv
// Purpose: user end of the fifo, driven by software over an APB slave
// Assumes: one pclk; write and read edges come from two tick dividers
// Notes: a data access stalls pready until the matching tick has passed
`timescale 1ns/100ps
`default_nettype none
module fifo_user #(
  parameter int WR_DIV = fifo_pkg::WR_DIV_DEFAULT,
  parameter int RD_DIV = fifo_pkg::RD_DIV_DEFAULT,
  parameter bit WE_HIGH = fifo_pkg::WE_HIGH_DEFAULT,
  parameter bit RE_HIGH = fifo_pkg::RE_HIGH_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  fifo_if.user f
);

  initial begin
    if (WR_DIV < 1 || WR_DIV > 255 || RD_DIV < 1 || RD_DIV > 255) begin
      $error("fifo_user tick dividers must lie in 1..255");
    end
  end

  typedef enum logic [2:0] {IDLE, WR_WAIT, RD_ISSUE, RD_PIPE, RD_DONE} step_e;

  step_e state;
  step_e next_state;
  logic [31:0] ctrl;
  logic [31:0] thresh;
  logic [7:0] wcnt;
  logic [7:0] rcnt;
  logic [31:0] rdata;

  // tick dividers stand in for the two slower clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcnt <= 8'h00;
      rcnt <= 8'h00;
    end else begin
      wcnt <= (wcnt == 8'(WR_DIV - 1)) ? 8'h00 : wcnt + 8'h01;
      rcnt <= (rcnt == 8'(RD_DIV - 1)) ? 8'h00 : rcnt + 8'h01;
    end
  end
  assign f.wr_tick = (wcnt == 8'(WR_DIV - 1));
  assign f.rd_tick = (rcnt == 8'(RD_DIV - 1));

  // address decode of the access phase
  wire access = psel & penable;
  wire hit_ctrl = (paddr == fifo_pkg::OFS_CTRL);
  wire hit_thr = (paddr == fifo_pkg::OFS_THRESH);
  wire hit_wd = (paddr == fifo_pkg::OFS_WDATA);
  wire hit_rd = (paddr == fifo_pkg::OFS_RDATA);
  wire hit_st = (paddr == fifo_pkg::OFS_STATUS);
  wire mapped = hit_ctrl | hit_thr | hit_wd | hit_rd | hit_st;
  wire wr_data_acc = access & pwrite & hit_wd;
  wire rd_data_acc = access & ~pwrite & hit_rd;

  // data accesses walk the sequencer; everything else answers at once
  always_comb begin
    next_state = state;
    case (state)
      IDLE: begin
        if (wr_data_acc) begin
          next_state = WR_WAIT;
        end else if (rd_data_acc) begin
          next_state = RD_ISSUE;
        end
      end
      WR_WAIT: next_state = f.wr_tick ? IDLE : WR_WAIT;
      RD_ISSUE: begin
        if (f.rd_tick) begin
          next_state = f.read_pipeline_select ? RD_PIPE : RD_DONE;
        end
      end
      RD_PIPE: next_state = f.rd_tick ? RD_DONE : RD_PIPE;
      RD_DONE: next_state = IDLE;
      default: next_state = IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= IDLE;
    end else begin
      state <= next_state;
    end
  end

  // write completes at its tick; read completes one cycle after its last tick
  wire data_acc = wr_data_acc | rd_data_acc;
  wire data_done = (state == WR_WAIT && f.wr_tick) || (state == RD_DONE);
  assign pready = ~data_acc | data_done;
  assign pslverr = access & ~mapped;

  // configuration registers, written at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= fifo_pkg::CTRL_RESET;
      thresh <= fifo_pkg::THRESH_RESET;
    end else if (access && pwrite && pready) begin
      if (hit_ctrl) begin
        ctrl <= {23'h000000, pwdata[8:0]};
      end
      if (hit_thr) begin
        thresh <= {4'h0, pwdata[27:16], 4'h0, pwdata[11:0]};
      end
    end
  end

  // read word is shown straight from the fifo output register while RD_DONE stands;
  // capturing it at the RD_DONE edge would hand software the word of the previous read
  assign rdata = {14'h0000, f.read_data_bus & fifo_pkg::data_mask(f.read_width_select)};

  wire [31:0] status = {28'h0000000, f.near_empty_flag, f.near_full_flag, f.empty, f.full};
  assign prdata = !access ? 32'h0000_0000
                : hit_ctrl ? ctrl
                : hit_thr ? thresh
                : hit_rd ? rdata
                : hit_st ? status
                : 32'h0000_0000;

  // fifo side: port enables held active; write and read enables active only while a data access waits for its tick
  wire want_wr = (state == WR_WAIT);
  wire want_rd = (state == RD_ISSUE);
  assign f.write_port_enable_n = 1'b0;
  assign f.read_port_enable_n = 1'b0;
  assign f.write_enable = WE_HIGH ? want_wr : ~want_wr;
  assign f.read_enable = RE_HIGH ? want_rd : ~want_rd;
  // bits above the write width are grounded
  assign f.write_data_bus = pwdata[17:0] & fifo_pkg::data_mask(f.write_width_select);
  assign f.write_width_select = ctrl[fifo_pkg::CTRL_WW_LSB +: 3];
  assign f.read_width_select = ctrl[fifo_pkg::CTRL_RW_LSB +: 3];
  assign f.read_pipeline_select = ctrl[fifo_pkg::CTRL_PIPE];
  assign f.empty_halt = ctrl[fifo_pkg::CTRL_EHALT];
  assign f.full_halt = ctrl[fifo_pkg::CTRL_FHALT];
  // thresholds are passed through as bit counts
  assign f.near_full_threshold = thresh[fifo_pkg::THR_NF_LSB +: 12];
  assign f.near_empty_threshold = thresh[fifo_pkg::THR_NE_LSB +: 12];

endmodule
`default_nettype wire

// File: sim/fifo_link_sva.sv
// Purpose: watch the fifo link between the controller and its user end
// Assumes: one pclk; tick lines mark the active edges of each side
// Notes: only link signals are seen, so stored words are judged by the bench
`timescale 1ns/100ps
`default_nettype none
module fifo_link_sva #(
  parameter bit WE_HIGH = fifo_pkg::WE_HIGH_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_tick,
  input wire logic write_port_enable_n,
  input wire logic write_enable,
  input wire logic [2:0] write_width_select,
  input wire logic rd_tick,
  input wire logic [2:0] read_width_select,
  input wire logic read_pipeline_select,
  input wire logic [11:0] near_full_threshold,
  input wire logic [11:0] near_empty_threshold,
  input wire logic [17:0] read_data_bus,
  input wire logic full,
  input wire logic empty,
  input wire logic near_full_flag,
  input wire logic near_empty_flag
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic wr_ev;
  logic p0;
  logic p1;
  logic aged;
  // accepted write on the link
  assign wr_ev = wr_tick && (write_enable == WE_HIGH) && !write_port_enable_n && !full;
  // age writes in read edges; aged drops once empty is low, as those writes are visible
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p0 <= 1'b0;
      p1 <= 1'b0;
      aged <= 1'b0;
    end else if (rd_tick) begin
      aged <= empty & (aged | p1);
      p1 <= p0;
      p0 <= wr_ev;
    end else begin
      aged <= empty & aged;
      p0 <= p0 | wr_ev;
    end
  end
  chk_reset_state: assert property (
    $rose(presetn) |-> empty && !full && near_empty_flag && read_data_bus == 18'h00000)
    else $error("flags or read data wrong after reset");
  chk_empty_release: assert property (
    $fell(empty) && $stable(read_width_select) |-> aged)
    else $error("empty fell before two read edges after a write");
  chk_empty_moves: assert property (
    $changed(empty) && $stable(read_width_select) |-> $past(rd_tick))
    else $error("empty changed without a read edge");
  chk_full_moves: assert property (
    $changed(full) && $stable(write_width_select) |-> $past(wr_tick))
    else $error("full changed without a write edge");
  chk_data_moves: assert property (
    $changed(read_data_bus) && $stable(read_pipeline_select) && $stable(read_width_select)
    |-> $past(rd_tick))
    else $error("read data changed without a read edge");
  chk_underflow_hold: assert property (
    rd_tick && empty && !read_pipeline_select
    |=> $stable(read_data_bus) || read_pipeline_select || $changed(read_width_select))
    else $error("read data changed on a read while empty");
  chk_near_full_zero: assert property (
    near_full_threshold == 12'h000 && $past(near_full_threshold) == 12'h000 |-> near_full_flag)
    else $error("near full low with zero threshold");
  chk_near_empty_max: assert property (
    near_empty_threshold == 12'hFFF && $past(near_empty_threshold) == 12'hFFF |-> near_empty_flag)
    else $error("near empty low with top threshold");
  cover property ($fell(empty));
  cover property ($rose(full));
  cover property (rd_tick && empty);
endmodule
`default_nettype wire

// File: sim/testbench.sv
// Purpose: drive the fifo user end over apb and judge the words and flags
// Assumes: default tick dividers and enable polarities
// Notes: pready and read data are sampled at the rising edge that takes the transfer
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic slv_err;
  int err_count;
  int checks;
  fifo_if bus ();
  fifo_ctrl i_fifo_ctrl (.pclk(pclk), .presetn(presetn), .f(bus));
  fifo_user i_fifo_user (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .f(bus));
  fifo_link_sva i_chk (.pclk(pclk), .presetn(presetn), .wr_tick(bus.wr_tick),
    .write_port_enable_n(bus.write_port_enable_n), .write_enable(bus.write_enable),
    .write_width_select(bus.write_width_select), .rd_tick(bus.rd_tick),
    .read_width_select(bus.read_width_select), .read_pipeline_select(bus.read_pipeline_select),
    .near_full_threshold(bus.near_full_threshold), .near_empty_threshold(bus.near_empty_threshold),
    .read_data_bus(bus.read_data_bus), .full(bus.full), .empty(bus.empty),
    .near_full_flag(bus.near_full_flag), .near_empty_flag(bus.near_empty_flag));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one apb transfer; data accesses stall until the fifo tick passes
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [17:0] word(input int n);
    word = 18'(n * 32'h407) ^ 18'h2C3A5;
  endfunction

  task automatic cfg(input logic [2:0] ww, input logic [2:0] rw, input logic pipe, input logic eh, input logic fh);
    logic [31:0] q;
    apb(1'b1, fifo_pkg::OFS_CTRL, {23'h0, fh, eh, pipe, rw, ww}, q);
  endtask

  // bounded poll, since flags cross with a sync delay
  task automatic poll(input logic [3:0] m, input logic [3:0] v, output logic [31:0] q);
    int k = 0;
    do begin
      apb(1'b0, fifo_pkg::OFS_STATUS, 32'h0, q);
      k++;
    end while ((q[3:0] & m) !== v && k < 50);
  endtask

  task automatic reset_check;
    logic [31:0] q;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    check("rdata_reset", {14'h0, bus.read_data_bus}, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, fifo_pkg::OFS_CTRL, 32'h0, q);
    check("ctrl_reset", q, fifo_pkg::CTRL_RESET);
    apb(1'b0, fifo_pkg::OFS_STATUS, 32'h0, q);
    check("status_reset", {28'h0, q[3:0]}, 32'hE);
  endtask

  // fill past full, drain in order, then read once more while empty
  task automatic fill_drain;
    logic [31:0] q;
    cfg(3'h4, 3'h4, 1'b1, 1'b1, 1'b1);
    apb(1'b1, 8'h20, 32'h0, q);
    check("unmapped_err", {31'h0, slv_err}, 32'h1);
    apb(1'b1, fifo_pkg::OFS_THRESH, 32'h0FFF_0000, q);
    // one and four 18-bit words scaled by 16
    apb(1'b1, fifo_pkg::OFS_THRESH, 32'h0010_0040, q);
    apb(1'b0, fifo_pkg::OFS_THRESH, 32'h0, q);
    check("thresh", q, 32'h0010_0040);
    for (int i = 0; i < 257; i++) begin
      apb(1'b1, fifo_pkg::OFS_WDATA, {14'h0, word(i)}, q);
      if (i == 2 || i == 3 || i >= 254) begin
        apb(1'b0, fifo_pkg::OFS_STATUS, 32'h0, q);
        if (i < 4) check("near_full", {31'h0, q[2]}, {31'h0, i == 3});
        else check("full", {31'h0, q[0]}, {31'h0, i >= 255});
      end
    end
    for (int i = 0; i < 256; i++) begin
      apb(1'b0, fifo_pkg::OFS_RDATA, 32'h0, q);
      check("fifo_word", {14'h0, q[17:0]}, {14'h0, word(i)});
      if (i == 253 || i == 254) begin
        apb(1'b0, fifo_pkg::OFS_STATUS, 32'h0, q);
        check("near_empty", {31'h0, q[3]}, {31'h0, i == 254});
      end
    end
    poll(4'h2, 4'h2, q);
    check("drained_empty", {31'h0, q[1]}, 32'h1);
    apb(1'b0, fifo_pkg::OFS_RDATA, 32'h0, q);
    check("underflow_hold", {14'h0, q[17:0]}, {14'h0, word(255)});
  endtask

  // two-bit writes against four-bit reads
  task automatic mixed_width;
    logic [31:0] q;
    cfg(3'h1, 3'h2, 1'b0, 1'b1, 1'b1);
    apb(1'b1, fifo_pkg::OFS_WDATA, 32'h1, q);
    repeat (4) apb(1'b0, fifo_pkg::OFS_STATUS, 32'h0, q);
    check("partial_empty", {31'h0, q[1]}, 32'h1);
    apb(1'b1, fifo_pkg::OFS_WDATA, 32'h2, q);
    poll(4'h2, 4'h0, q);
    check("whole_word", {31'h0, q[1]}, 32'h0);
    apb(1'b0, fifo_pkg::OFS_RDATA, 32'h0, q);
    check("mixed_word", {28'h0, q[3:0]}, 32'h9);
  endtask

  // every width code, widest first so each step stays aligned
  task automatic widths;
    logic [31:0] q;
    logic [17:0] d;
    logic [17:0] m;
    for (int c = 4; c >= 0; c--) begin
      m = (c == 4) ? 18'h3FFFF : (c == 3) ? 18'h001FF : 18'((1 << (1 << c)) - 1);
      d = word(c + 7) & m;
      cfg(3'(c), 3'(c), c[0], 1'b1, 1'b1);
      apb(1'b1, fifo_pkg::OFS_WDATA, {14'h0, d}, q);
      poll(4'h2, 4'h0, q);
      apb(1'b0, fifo_pkg::OFS_RDATA, 32'h0, q);
      check("width_word", {14'h0, q[17:0] & m}, {14'h0, d});
      check("bus_word", {14'h0, bus.read_data_bus & m}, {14'h0, d});
    end
    cfg(3'h5, 3'h5, 1'b0, 1'b1, 1'b1);
    apb(1'b1, fifo_pkg::OFS_WDATA, 32'h0003_FFFF, q);
    cfg(3'h0, 3'h0, 1'b0, 1'b1, 1'b1);
    repeat (4) apb(1'b0, fifo_pkg::OFS_STATUS, 32'h0, q);
    check("reserved_nop", {31'h0, q[1]}, 32'h1);
  endtask

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    checks = 0;
    reset_check();
    fill_drain();
    mixed_width();
    reset_check();
    widths();
    stop_test();
  end

  // the whole run needs well under this many cycles
  initial begin
    repeat (60000) @(posedge pclk);
    err_count++;
    $display("[ERR] watchdog expected done seen timeout");
    stop_test();
  end
endmodule
`default_nettype wire
